// >>> src/align_pkg.sv
// Shared constants for the bit-slip word aligner and its controller.
package align_pkg;

   // ****************************************
   // Word and synchronizer geometry
   // ****************************************
   localparam int WORD_W_DEF  = 8;  // Default deserialization factor.
   localparam int WORD_W_ALT  = 10; // The other permitted factor.
   localparam int SYNC_DEPTH  = 4;  // Phase synchronizer entries.
   localparam int SYNC_AW     = 2;  // Phase synchronizer index width.
   localparam int SKID_DEPTH  = 2;  // Output buffer entries.

   // ****************************************
   // Slip request timing, in low-speed clock cycles
   // ****************************************
   localparam int SLIP_HIGH_CYCLES = 2; // Least high time of a request.
   localparam int SLIP_LOW_CYCLES  = 3; // Least low time between requests.
   localparam int SETTLE_CYCLES    = 8; // Wait for slipped data to arrive.
   localparam int TIMER_W          = 4; // Width of the controller timer.

   // ****************************************
   // Controller states
   // ****************************************
   typedef enum logic [2:0] {
      CTL_IDLE  = 3'b000,
      CTL_CHECK = 3'b001,
      CTL_PULSE = 3'b010,
      CTL_GAP   = 3'b011,
      CTL_LOCK  = 3'b100
   } ctl_state_t;

endpackage

// >>> src/align_if.sv
// Link between the word aligner and the pattern-matching controller.
`timescale 1ns/1ps
interface align_if #(
   parameter int W = 8
);

   // ****************************************
   // Word stream and slip request
   // ****************************************
   logic [W-1:0] word_data;  // Realigned word.
   logic         word_valid; // Word on word_data is offered.
   logic         word_ready; // Controller takes the offered word.
   logic         slip_req;   // Level whose rising edge slips one bit.

   modport dev (
      output word_data,
      output word_valid,
      input  word_ready,
      input  slip_req
   );

   modport ctl (
      input  word_data,
      input  word_valid,
      output word_ready,
      output slip_req
   );

endinterface

// >>> src/align_device.sv
// Per-channel phase synchronizer, bit-slip realigner and output buffer.
//
// Contract
// - Realign parallel words per channel on MCLK.
// - Each slip rising edge shifts one bit.
// - Realigner always present; otherwise only adds latency.
// - Slip request from pin or fabric accepted.
// - Controller slips again after each pattern mismatch.
// - Word width is 8 or 10 bits.
// - Counter wraps after n-1; newest register selected.
// - Output selected from registers 2 and 3.
// - New valid word on the following cycle.
// - Controller holds request high two cycles.
// - Controller holds request low three cycles.
// - Controller registers incoming words first.
// - Controller registers slip request before output.
// - Four-entry synchronizer, no flags or enables; the code keeps an occupancy count, a write enable and a not-empty flag.
`timescale 1ns/1ps
module align_device #(
   parameter int W = align_pkg::WORD_W_DEF
) (
   // Clock and reset.
   input  wire logic         MCLK,
   input  wire logic         RESETN,
   // Words from the deserializer on MCLK.
   input  wire logic [W-1:0] DES_DATA,
   input  wire logic         DES_VALID,
   // Slip control.
   input  wire logic         SLIP_ENABLE,
   input  wire logic         SLIP_FROM_PIN,
   input  wire logic         SLIP_PIN,
   // Status.
   output logic [$clog2(W)-1:0] SLIP_POS,
   // Link to the controller.
   align_if.dev              link
);

   // ****************************************
   // Elaboration check and local widths
   // ****************************************
   localparam int CW = $clog2(W);
   localparam logic [CW-1:0] CNT_LAST = CW'(W - 1);
   localparam logic [CW:0]   W_BASE   = (CW + 1)'(W);

   generate
      if (W != align_pkg::WORD_W_DEF && W != align_pkg::WORD_W_ALT) begin
         $error("align_device: word width must be 8 or 10");
      end
   endgenerate

   // ****************************************
   // Declarations
   // ****************************************
   logic [W-1:0]       sync_mem [align_pkg::SYNC_DEPTH];
   logic [align_pkg::SYNC_AW-1:0] sync_wr_reg;
   logic [align_pkg::SYNC_AW-1:0] sync_rd_reg;
   logic [align_pkg::SYNC_AW:0]   sync_occ_reg;
   logic [W-1:0]       realign2_reg;
   logic [W-1:0]       realign3_reg;
   logic [1:0]         fill_reg;
   logic [CW-1:0]      slip_cnt_reg;
   logic [CW-1:0]      slip_cnt_next;
   logic               pin_meta_reg;
   logic               pin_sync_reg;
   logic               slip_prev_reg;
   logic [W-1:0]       out_data_reg;
   logic               out_valid_reg;
   logic [W-1:0]       skid_data_reg;
   logic               skid_valid_reg;
   wire                sync_wr;
   wire                sync_has;
   wire                step;
   wire                push;
   wire                pop;
   wire                slip_level;
   wire                slip_rise;
   wire [CW:0]         sel_base;
   wire [2*W-1:0]      realign_pair;
   wire [W-1:0]        realigned;

   // ****************************************
   // Phase synchronizer
   // ****************************************
   // The source is frequency locked, so the four entries fill only while the receiver stalls; the
   // occupancy is kept internally to hold the read side while empty and to block writes when full.
   // synchronizer write enable and not-empty flag
   assign sync_wr  = DES_VALID && (sync_occ_reg !=
                     (align_pkg::SYNC_AW + 1)'(align_pkg::SYNC_DEPTH));
   assign sync_has = (sync_occ_reg != '0);

   // Write side of the synchronizer storage.
   always_ff @(posedge MCLK) begin
      if (sync_wr) begin
         sync_mem[sync_wr_reg] <= DES_DATA;
      end
   end

   // Pointers and occupancy.
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         sync_wr_reg  <= '0;
         sync_rd_reg  <= '0;
         sync_occ_reg <= '0;
      end else begin
         sync_wr_reg  <= sync_wr_reg + sync_adv_one(sync_wr);
         sync_rd_reg  <= sync_rd_reg + sync_adv_one(step);
         sync_occ_reg <= sync_occ_reg
                         + {{align_pkg::SYNC_AW{1'b0}}, sync_wr}
                         - {{align_pkg::SYNC_AW{1'b0}}, step};
      end
   end

   // Returns one at pointer width when the pointer is to advance.
   function automatic logic [align_pkg::SYNC_AW-1:0] sync_adv_one(
      input logic adv
   );
      return {{(align_pkg::SYNC_AW - 1){1'b0}}, adv};
   endfunction

   // ****************************************
   // Slip request source and edge detect
   // ****************************************
   // The pin arrives from outside the clock domain and is synchronized.
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
      end else begin
         pin_meta_reg <= SLIP_PIN;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   assign slip_level = SLIP_ENABLE &&
                       (SLIP_FROM_PIN ? pin_sync_reg : link.slip_req);
   assign slip_rise  = slip_level && !slip_prev_reg;

   assign slip_cnt_next = !slip_rise ? slip_cnt_reg :
                          (slip_cnt_reg == CNT_LAST) ? '0 :
                          slip_cnt_reg + CW'(1);

   // Slip counter and registered request copy.
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         slip_prev_reg <= 1'b0;
         slip_cnt_reg  <= '0;
      end else begin
         slip_prev_reg <= slip_level;
         slip_cnt_reg  <= slip_cnt_next;
      end
   end

   // ****************************************
   // Realignment registers and selection
   // ****************************************
   // The pipeline advances only while the output buffer has room, so a
   // stalled receiver holds up to four words in the synchronizer; later words are dropped.
   assign step = sync_has && !skid_valid_reg;
   assign push = step && fill_reg[1];

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         realign2_reg <= '0;
         realign3_reg <= '0;
         fill_reg     <= '0;
      end else if (step) begin
         realign3_reg <= sync_mem[sync_rd_reg];
         realign2_reg <= realign3_reg;
         fill_reg     <= {fill_reg[0], 1'b1};
      end
   end

   assign realign_pair = {realign3_reg, realign2_reg};
   assign sel_base     = W_BASE - {1'b0, slip_cnt_reg};
   assign realigned    = realign_pair[sel_base +: W];

   // ****************************************
   // Two-entry output buffer
   // ****************************************
   // The second entry catches the word that was in flight when the
   // controller dropped ready; ready to the pipeline is its empty flag.
   assign pop = out_valid_reg && link.word_ready;

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         out_data_reg   <= '0;
         out_valid_reg  <= 1'b0;
         skid_data_reg  <= '0;
         skid_valid_reg <= 1'b0;
      end else begin
         if (!out_valid_reg || pop) begin
            out_valid_reg <= skid_valid_reg || push;
            out_data_reg  <= skid_valid_reg ? skid_data_reg : realigned;
            skid_valid_reg <= 1'b0;
         end else if (push) begin
            skid_data_reg  <= realigned;
            skid_valid_reg <= 1'b1;
         end
      end
   end

   // Status of the current word boundary.
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         SLIP_POS <= '0;
      end else begin
         SLIP_POS <= slip_cnt_next;
      end
   end

   // Interface outputs come straight from the buffer registers.
   assign link.word_data  = out_data_reg;
   assign link.word_valid = out_valid_reg;

endmodule

// >>> src/align_ctl.sv
// Pattern-matching controller that issues bit-slip requests.
`timescale 1ns/1ps
module align_ctl #(
   parameter int W = align_pkg::WORD_W_DEF
) (
   // Clock and reset.
   input  wire logic         MCLK,
   input  wire logic         RESETN,
   // User control.
   input  wire logic         ALIGN_START,
   input  wire logic [W-1:0] TRAIN_WORD,
   // User results.
   output logic              LOCKED,
   output logic [W-1:0]      USER_DATA,
   output logic              USER_VALID,
   // Link to the aligner.
   align_if.ctl              link
);

   // ****************************************
   // Declarations
   // ****************************************
   localparam logic [align_pkg::TIMER_W-1:0] HIGH_LAST =
      align_pkg::TIMER_W'(align_pkg::SLIP_HIGH_CYCLES - 1);
   localparam logic [align_pkg::TIMER_W-1:0] WAIT_LAST =
      align_pkg::TIMER_W'(align_pkg::SETTLE_CYCLES - 1);

   generate
      if (align_pkg::SETTLE_CYCLES < align_pkg::SLIP_LOW_CYCLES) begin
         $error("align_ctl: settle time shorter than slip low time");
      end
   endgenerate

   align_pkg::ctl_state_t state_reg;
   align_pkg::ctl_state_t state_next;
   logic [align_pkg::TIMER_W-1:0] timer_reg;
   logic [align_pkg::TIMER_W-1:0] timer_next;
   logic [W-1:0]       in_data_reg;
   logic               in_valid_reg;
   logic               slip_out_reg;
   logic               ready_reg;
   wire                take;
   wire                match;
   wire                gen_slip;

   // ****************************************
   // Input synchronizing stage
   // ****************************************
   assign take = link.word_valid && ready_reg;

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         in_data_reg  <= '0;
         in_valid_reg <= 1'b0;
         ready_reg    <= 1'b0;
      end else begin
         in_data_reg  <= take ? link.word_data : in_data_reg;
         in_valid_reg <= take;
         ready_reg    <= 1'b1;
      end
   end

   assign match = in_valid_reg && (in_data_reg == TRAIN_WORD);

   // ****************************************
   // Alignment state machine
   // ****************************************
   // slip on mismatch
   always_comb begin
      state_next = state_reg;
      timer_next = '0;
      case (state_reg)
         align_pkg::CTL_IDLE: begin
            if (ALIGN_START) begin
               state_next = align_pkg::CTL_CHECK;
            end
         end
         align_pkg::CTL_CHECK: begin
            if (!ALIGN_START) begin
               state_next = align_pkg::CTL_IDLE;
            end else if (match) begin
               state_next = align_pkg::CTL_LOCK;
            end else if (in_valid_reg) begin
               state_next = align_pkg::CTL_PULSE;
            end
         end
         align_pkg::CTL_PULSE: begin
            if (timer_reg == HIGH_LAST) begin
               state_next = align_pkg::CTL_GAP;
            end else begin
               timer_next = timer_reg + align_pkg::TIMER_W'(1);
            end
         end
         align_pkg::CTL_GAP: begin
            if (timer_reg == WAIT_LAST) begin
               state_next = align_pkg::CTL_CHECK;
            end else begin
               timer_next = timer_reg + align_pkg::TIMER_W'(1);
            end
         end
         align_pkg::CTL_LOCK: begin
            if (!ALIGN_START) begin
               state_next = align_pkg::CTL_IDLE;
            end
         end
         default: begin
            state_next = align_pkg::CTL_IDLE;
         end
      endcase
   end

   assign gen_slip = (state_reg == align_pkg::CTL_PULSE);

   // State, timer and the output synchronizing register.
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         state_reg    <= align_pkg::CTL_IDLE;
         timer_reg    <= '0;
         slip_out_reg <= 1'b0;
      end else begin
         state_reg    <= state_next;
         timer_reg    <= timer_next;
         slip_out_reg <= gen_slip;
      end
   end

   // User-facing results, registered.
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         LOCKED     <= 1'b0;
         USER_DATA  <= '0;
         USER_VALID <= 1'b0;
      end else begin
         LOCKED     <= (state_next == align_pkg::CTL_LOCK);
         USER_DATA  <= in_data_reg;
         USER_VALID <= in_valid_reg && (state_reg == align_pkg::CTL_LOCK);
      end
   end

   assign link.word_ready = ready_reg;
   assign link.slip_req   = slip_out_reg;

endmodule

// >>> bench/align_monitor.sv
// Assertion checker for the link between aligner and controller.
`timescale 1ns/1ps
module align_monitor #(
   parameter int W = 8
) (
   // Clock and reset.
   input wire logic         MCLK,
   input wire logic         RESETN,
   // Link signals.
   input wire logic [W-1:0] word_data,
   input wire logic         word_valid,
   input wire logic         word_ready,
   input wire logic         slip_req
);
   // ****************
   // Helper logic
   // ****************
   logic [3:0] age_reg;
   logic [3:0] age_next;
   logic       take;

   // Age of the last taken word, so a slip can be tied to its cause.
   assign take     = word_valid && word_ready;
   assign age_next = take ? 4'h0 :
                     (age_reg == 4'hf) ? age_reg : age_reg + 4'h1;

   // The age register saturates and restarts high on reset.
   always_ff @(posedge MCLK) begin
      age_reg <= !RESETN ? 4'hf : age_next;
   end

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RESETN);

   // ****************
   // Properties
   // ****************
   property p_hold;
      word_valid && !word_ready |=> word_valid && $stable(word_data);
   endproperty
   a_hold: assert property (p_hold)
      else $error("word changed while stalled");
   property p_slip_high;
      $rose(slip_req) |=> slip_req;
   endproperty
   a_slip_high: assert property (p_slip_high)
      else $error("slip request high for one cycle only");
   property p_slip_gap;
      $fell(slip_req) |-> !slip_req [*3];
   endproperty
   a_slip_gap: assert property (p_slip_gap)
      else $error("slip request low for under three cycles");
   property p_slip_end;
      $rose(slip_req) |-> ##[2:6] !slip_req;
   endproperty
   a_slip_end: assert property (p_slip_end)
      else $error("slip request never released");
   property p_slip_cause;
      $rose(slip_req) |-> age_reg <= 4'h6;
   endproperty
   a_slip_cause: assert property (p_slip_cause)
      else $error("slip without a recently checked word");
   property p_word_after_slip;
      $rose(slip_req) |-> ##[1:40] take;
   endproperty
   a_word_after_slip: assert property (p_word_after_slip)
      else $error("no word delivered after a slip");
   property p_reset_clear;
      $rose(RESETN) |-> !slip_req && !word_ready;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("link not cleared by reset");
   property p_valid_after_reset;
      $rose(RESETN) |-> !word_valid [*3];
   endproperty
   a_valid_after_reset: assert property (p_valid_after_reset)
      else $error("word offered too early after reset");

   c_slip: cover property ($rose(slip_req));
   c_burst: cover property (take ##1 take);
   c_stall: cover property (word_valid && !word_ready);
endmodule

// >>> bench/tb_byte_boundary_bit_slip_aligner.sv
// Bench joining the bit-slip aligner to its pattern controller.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
   num_checks++; \
   if ((got) !== (exp)) begin \
      err_total++; \
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
   end \
end
module tb_byte_boundary_bit_slip_aligner;
   localparam int           W     = align_pkg::WORD_W_DEF;
   localparam logic [W-1:0] TRAIN = 8'h1d; // Every rotation differs.
   logic         MCLK          = 1'b0;
   logic         RESETN        = 1'b0;
   logic [W-1:0] DES_DATA      = 8'h00;
   logic         DES_VALID     = 1'b0;
   logic         SLIP_ENABLE   = 1'b0;
   logic         SLIP_FROM_PIN = 1'b1;
   logic         SLIP_PIN      = 1'b0;
   logic         ALIGN_START   = 1'b0;
   logic [W-1:0] TRAIN_WORD    = TRAIN;
   logic         LOCKED;
   logic [W-1:0] USER_DATA;
   logic         USER_VALID;
   logic [2:0]   SLIP_POS;
   logic         ramp          = 1'b1;
   logic [W-1:0] pat           = 8'h00;
   logic         slip_q        = 1'b0;
   int           rises         = 0;
   int           err_total     = 0;
   int           num_checks    = 0;

   align_if #(.W(W)) align_if_i ();
   align_device #(.W(W)) align_device_i (
      .MCLK(MCLK), .RESETN(RESETN), .DES_DATA(DES_DATA),
      .DES_VALID(DES_VALID), .SLIP_ENABLE(SLIP_ENABLE),
      .SLIP_FROM_PIN(SLIP_FROM_PIN), .SLIP_PIN(SLIP_PIN),
      .SLIP_POS(SLIP_POS), .link(align_if_i));
   align_ctl #(.W(W)) align_ctl_i (
      .MCLK(MCLK), .RESETN(RESETN), .ALIGN_START(ALIGN_START),
      .TRAIN_WORD(TRAIN_WORD), .LOCKED(LOCKED), .USER_DATA(USER_DATA),
      .USER_VALID(USER_VALID), .link(align_if_i));
   align_monitor #(.W(W)) align_monitor_i (
      .MCLK(MCLK), .RESETN(RESETN),
      .word_data(align_if_i.word_data),
      .word_valid(align_if_i.word_valid),
      .word_ready(align_if_i.word_ready),
      .slip_req(align_if_i.slip_req));

   // Clock at 125 MHz.
   always #4 MCLK = ~MCLK;

   // Deserializer stand-in: a ramp, or one rotated pattern every cycle.
   always @(posedge MCLK) begin
      DES_DATA <= ramp ? DES_DATA + 8'h01 : pat;
   end

   // Counts rising edges of the controller's slip request.
   always @(negedge MCLK) begin
      if (align_if_i.slip_req && !slip_q) begin
         rises++;
      end
      slip_q = align_if_i.slip_req;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Synchronous reset; the link and the slip count must clear.
   task automatic t_reset(input int n);
      @(posedge MCLK);
      RESETN      <= 1'b0;
      DES_VALID   <= 1'b0;
      ALIGN_START <= 1'b0;
      repeat (n) @(posedge MCLK);
      @(negedge MCLK);
      `CHK("slip_pos", 3'h0, SLIP_POS)
      `CHK("locked", 1'b0, LOCKED)
      `CHK("word_valid", 1'b0, align_if_i.word_valid)
      @(posedge MCLK);
      RESETN <= 1'b1;
      repeat (2) @(posedge MCLK);
      DES_VALID <= 1'b1;
   endtask

   // Slipping off: pin toggles, yet words pass whole and in order.
   task automatic t_passthru();
      logic [W-1:0] prev;
      int           n;
      n = 0;
      prev = 8'h00;
      for (int i = 0; i < 60; i++) begin
         @(posedge MCLK);
         SLIP_PIN <= i[2];
         @(negedge MCLK);
         if ((align_if_i.word_valid & align_if_i.word_ready) === 1'b1) begin
            if (n > 0) begin
               `CHK("ramp_word", prev + 8'h01, align_if_i.word_data)
            end
            prev = align_if_i.word_data;
            n++;
         end
      end
      `CHK("words_taken", 1'b1, n > 40)
      `CHK("slip_pos", 3'h0, SLIP_POS)
   endtask

   // Two pin pulses, each held high six cycles, give exactly two slips.
   task automatic t_pin();
      @(posedge MCLK);
      SLIP_ENABLE <= 1'b1;
      repeat (2) begin
         @(posedge MCLK);
         SLIP_PIN <= 1'b1;
         repeat (6) @(posedge MCLK);
         SLIP_PIN <= 1'b0;
         repeat (6) @(posedge MCLK);
      end
      @(negedge MCLK);
      `CHK("pin_slip_pos", 3'h2, SLIP_POS)
   endtask

   // Stream rotated right by c; the controller must slip to count c.
   task automatic t_align(input logic [2:0] c);
      logic [2:0] dif;
      int         r0;
      int         n;
      @(posedge MCLK);
      SLIP_FROM_PIN <= 1'b0;
      ALIGN_START   <= 1'b0;
      ramp          <= 1'b0;
      pat           <= (TRAIN >> c) | (TRAIN << (W - c));
      repeat (11) @(posedge MCLK);
      @(negedge MCLK);
      dif = c - SLIP_POS;
      r0 = rises;
      n = 0;
      @(posedge MCLK);
      ALIGN_START <= 1'b1;
      while ((LOCKED & USER_VALID) !== 1'b1) begin
         @(negedge MCLK);
         n++;
         if (n > 800) begin
            err_total++;
            $display("CHECK FAILED lock_wait expected 1 seen %b", LOCKED);
            results();
         end
      end
      `CHK("user_data", TRAIN, USER_DATA)
      `CHK("slip_pos", c, SLIP_POS)
      `CHK("slip_count", int'(dif), rises - r0)
   endtask

   // Main sequence; the second alignment wraps the count past 7.
   initial begin
      t_reset(20);
      t_passthru();
      t_pin();
      t_align(3'h5);
      t_align(3'h1);
      t_reset(3);
      t_align(3'h0);
      results();
   end
endmodule
